//--- rtl/pmsc_clk_div.v
`timescale 1ns/1ps
`include "pmsc_defines.vh"
module pmsc_clk_div (
    input  wire       mclk,      // system clock
    input  wire       rst_n,     // async reset, active low
    input  wire [1:0] div_sel,   // medium divider code
    output reg        tick       // one-cycle enable at divided rate
);
    reg  [`PMSC_DIV_W-1:0] cnt;
    reg  [`PMSC_DIV_W-1:0] mask;
    wire [`PMSC_DIV_W-1:0] next_cnt;

    // ----------------------------------------------------------------
    // code to wrap mask
    // ----------------------------------------------------------------
    always @* begin
        case (div_sel)
            2'h0:    mask = `PMSC_DIV16_MASK;
            2'h1:    mask = `PMSC_DIV32_MASK;
            2'h2:    mask = `PMSC_DIV64_MASK;
            default: mask = `PMSC_DIV128_MASK;
        endcase
    end

    assign next_cnt = ((cnt & mask) == mask) ? {`PMSC_DIV_W{1'b0}} : cnt + 7'h01;

    // ----------------------------------------------------------------
    // counter and tick, tick registered one cycle after the last count of each period
    // ----------------------------------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt  <= {`PMSC_DIV_W{1'b0}};
            tick <= 1'b0;
        end else begin
            cnt  <= next_cnt & mask;
            tick <= ((cnt & mask) == mask);
        end
    end
endmodule // pmsc_clk_div

//--- rtl/pmsc_defines.vh
// How it works
// - Standby select set: sleep in active mode enters standby or watch, not sleep.
// - Standby select set: sleep in subactive mode enters watch mode.
// - Medium-speed flag clear: CPU runs active high-speed on the undivided clock.
// - Medium-speed flag is bit 2 of clock mode control, read/write, resets 0.
`ifndef PMSC_DEFINES_VH
`define PMSC_DEFINES_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define PMSC_ADDR_W         12
`define PMSC_OFS_SSC        12'h000
`define PMSC_OFS_CMC        12'h004
`define PMSC_OFS_STAT       12'h008

// ----------------------------------------------------------------
// standby and speed control fields
// ----------------------------------------------------------------
`define PMSC_SSC_RESET      8'h07
`define PMSC_SSC_SBY_BIT    7
`define PMSC_SSC_WAIT_HI    6
`define PMSC_SSC_WAIT_LO    4
`define PMSC_SSC_LOW_SPEED_FLAG_BIT   3
`define PMSC_SSC_RSV_BIT    2
`define PMSC_SSC_MDIV_HI    1
`define PMSC_SSC_MDIV_LO    0

// ----------------------------------------------------------------
// clock mode control fields
// ----------------------------------------------------------------
`define PMSC_CMC_RESET      8'hF0
`define PMSC_CMC_RSV_MASK   8'hE0
`define PMSC_CMC_NSEL_BIT   4
`define PMSC_CMC_DTE_BIT    3
`define PMSC_CMC_MEDIUM_SPEED_FLAG_BIT   2
`define PMSC_CMC_SDIV_HI    1
`define PMSC_CMC_SDIV_LO    0

// ----------------------------------------------------------------
// operating modes
// ----------------------------------------------------------------
`define PMSC_MODE_ACTIVE    3'h0
`define PMSC_MODE_SUBACT    3'h1
`define PMSC_MODE_SLEEP     3'h2
`define PMSC_MODE_SUBSLEEP  3'h3
`define PMSC_MODE_STANDBY   3'h4
`define PMSC_MODE_WATCH     3'h5

// ----------------------------------------------------------------
// medium-speed divider masks, count wraps at mask
// ----------------------------------------------------------------
`define PMSC_DIV_W          7
`define PMSC_DIV16_MASK     7'h0F
`define PMSC_DIV32_MASK     7'h1F
`define PMSC_DIV64_MASK     7'h3F
`define PMSC_DIV128_MASK    7'h7F

`endif

//--- rtl/pmsc_sync3.v
`timescale 1ns/1ps
module pmsc_sync3 (
    input  wire mclk,     // system clock
    input  wire rst_n,    // async reset, active low
    input  wire din,      // asynchronous input
    output reg  level,    // filtered level
    output reg  rise      // one-cycle pulse on accepted rising change
);
    reg q1;
    reg q2;
    reg q3;

    // ----------------------------------------------------------------
    // three stages, change accepted once stages two and three agree
    // ----------------------------------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q1    <= 1'b0;
            q2    <= 1'b0;
            q3    <= 1'b0;
            level <= 1'b0;
            rise  <= 1'b0;
        end else begin
            q1    <= din;
            q2    <= q1;
            q3    <= q2;
            rise  <= 1'b0;
            if (q2 == q3) begin
                level <= q3;
                rise  <= q3 & ~level;
            end
        end
    end
endmodule // pmsc_sync3

//--- rtl/pmsc_top.v
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "pmsc_defines.vh"
module pmsc_top (
    input  wire        mclk,                     // system clock, 20 MHz
    input  wire        rst_n,                    // async reset, active low
    input  wire        psel,                     // apb select
    input  wire        penable,                  // apb access phase
    input  wire        pwrite,                   // apb direction, 1 write
    input  wire [11:0] paddr,                    // apb byte address
    input  wire [31:0] pwdata,                   // apb write data
    input  wire [3:0]  pstrb,                    // apb byte strobes
    output wire        pready,                   // apb ready
    output reg  [31:0] prdata,                   // apb read data
    output reg         pslverr,                  // apb error on unmapped address
    input  wire        sleep_req,                // sleep instruction pulse
    input  wire        wake_req,                 // wakeup event pulse
    input  wire        watch_timer_on,           // watch timer running, same clock
    input  wire        sub_clk_in,               // subclock from pin, asynchronous
    output reg         cpu_clk_en,               // cpu clock enable pulse
    output reg  [2:0]  op_mode,                  // current operating mode
    output wire        standby_select,           // sleep goes to standby or watch
    output wire [2:0]  standby_wait_sel,         // standby wait time code
    output wire        low_speed_flag,           // cpu on subclock after watch
    output wire        medium_speed_flag,        // active medium-speed mode
    output wire [1:0]  medium_divider,           // medium divider code
    output wire [1:0]  subactive_divider,        // subactive divider code
    output wire        noise_sample_select,      // noise filter sample rate
    output wire        direct_transition_enable  // direct transition enable
);
    reg  [7:0] ssc_reg;
    reg  [7:0] cmc_reg;
    reg  [2:0] next_mode;
    reg [31:0] next_rdata;
    reg        next_err;
    reg        next_en;
    wire       setup;
    wire       wr_fire;
    wire       hit_ssc;
    wire       hit_cmc;
    wire       hit_stat;
    wire       med_tick;
    wire       sub_level;
    wire       sub_rise;

    // ----------------------------------------------------------------
    // register fields
    // ----------------------------------------------------------------
    assign standby_select      = ssc_reg[`PMSC_SSC_SBY_BIT];
    assign standby_wait_sel    = ssc_reg[`PMSC_SSC_WAIT_HI:`PMSC_SSC_WAIT_LO];
    assign low_speed_flag      = ssc_reg[`PMSC_SSC_LOW_SPEED_FLAG_BIT];
    assign medium_divider      = ssc_reg[`PMSC_SSC_MDIV_HI:`PMSC_SSC_MDIV_LO];
    assign medium_speed_flag   = cmc_reg[`PMSC_CMC_MEDIUM_SPEED_FLAG_BIT];
    assign subactive_divider   = cmc_reg[`PMSC_CMC_SDIV_HI:`PMSC_CMC_SDIV_LO];
    assign noise_sample_select = cmc_reg[`PMSC_CMC_NSEL_BIT];
    assign direct_transition_enable = cmc_reg[`PMSC_CMC_DTE_BIT];

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign setup    = psel & ~penable;
    assign pready   = 1'b1;
    assign wr_fire  = psel & penable & pwrite & pstrb[0];
    assign hit_ssc  = (paddr == `PMSC_OFS_SSC);
    assign hit_cmc  = (paddr == `PMSC_OFS_CMC);
    assign hit_stat = (paddr == `PMSC_OFS_STAT);

    // read data and error prepared in setup, held through access
    always @* begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        if (hit_ssc) begin
            next_rdata[7:0] = ssc_reg;
        end else if (hit_cmc) begin
            next_rdata[7:0] = cmc_reg;
        end else if (hit_stat) begin
            next_rdata[2:0] = op_mode;
            next_rdata[3]   = medium_speed_flag;
        end else begin
            next_err = 1'b1;
        end
        if (pwrite) begin
            next_rdata = 32'h0000_0000;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= next_rdata;
            pslverr <= next_err;
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ssc_reg <= `PMSC_SSC_RESET;
            cmc_reg <= `PMSC_CMC_RESET;
        end else if (wr_fire) begin
            if (hit_ssc) begin
                ssc_reg <= pwdata[7:0] | (8'h01 << `PMSC_SSC_RSV_BIT);
            end
            if (hit_cmc) begin
                cmc_reg <= pwdata[7:0] | `PMSC_CMC_RSV_MASK;
            end
        end
    end

    // ----------------------------------------------------------------
    // subclock input and medium divider
    // ----------------------------------------------------------------
    pmsc_sync3 u_sub_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .din   (sub_clk_in),
        .level (sub_level),
        .rise  (sub_rise)
    );

    pmsc_clk_div u_med_div (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .div_sel (medium_divider),
        .tick    (med_tick)
    );

    // ----------------------------------------------------------------
    // mode transitions
    // ----------------------------------------------------------------
    always @* begin
        next_mode = op_mode;
        case (op_mode)
            `PMSC_MODE_ACTIVE: begin
                if (sleep_req) begin
                    if (standby_select) begin
                        next_mode = watch_timer_on ? `PMSC_MODE_WATCH
                                                   : `PMSC_MODE_STANDBY;
                    end else begin
                        next_mode = `PMSC_MODE_SLEEP;
                    end
                end
            end
            `PMSC_MODE_SUBACT: begin
                if (sleep_req) begin
                    next_mode = standby_select ? `PMSC_MODE_WATCH
                                               : `PMSC_MODE_SUBSLEEP;
                end
            end
            `PMSC_MODE_SLEEP: begin
                if (wake_req) begin
                    next_mode = `PMSC_MODE_ACTIVE;
                end
            end
            `PMSC_MODE_SUBSLEEP: begin
                if (wake_req) begin
                    next_mode = `PMSC_MODE_SUBACT;
                end
            end
            `PMSC_MODE_STANDBY: begin
                if (wake_req) begin
                    next_mode = `PMSC_MODE_ACTIVE;
                end
            end
            `PMSC_MODE_WATCH: begin
                if (wake_req) begin
                    next_mode = low_speed_flag ? `PMSC_MODE_SUBACT
                                               : `PMSC_MODE_ACTIVE;
                end
            end
            default: begin
                next_mode = `PMSC_MODE_ACTIVE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // cpu clock enable per mode
    // ----------------------------------------------------------------
    always @* begin
        case (op_mode)
            `PMSC_MODE_ACTIVE: begin
                next_en = medium_speed_flag ? med_tick
                                            : 1'b1;
            end
            `PMSC_MODE_SUBACT: begin
                next_en = sub_rise;
            end
            default: begin
                next_en = 1'b0;
            end
        endcase
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            op_mode    <= `PMSC_MODE_ACTIVE;
            cpu_clk_en <= 1'b0;
        end else begin
            op_mode    <= next_mode;
            cpu_clk_en <= next_en;
        end
    end

    // sub_level kept for visibility of the filtered subclock level
    wire unused_sub_level = sub_level;
endmodule // pmsc_top

//--- tb/pmsc_chk.sv
`timescale 1ns/1ps
`include "pmsc_defines.vh"
module pmsc_chk (
    input wire        mclk,              // clock
    input wire        rst_n,             // reset
    input wire        psel,              // select
    input wire        penable,           // access
    input wire        pwrite,            // write
    input wire [11:0] paddr,             // address
    input wire [31:0] pwdata,            // wdata
    input wire [3:0]  pstrb,             // strobes
    input wire        pready,            // ready
    input wire        sleep_req,         // sleep
    input wire        cpu_clk_en,        // cpu enable
    input wire [2:0]  op_mode,           // mode
    input wire        standby_select,    // standby
    input wire        medium_speed_flag, // medium on
    input wire [1:0]  medium_divider     // divider
);
// ----------
// pulse spacing counters
// ----------
reg  [7:0] stable;
reg  [7:0] gap;
reg  [1:0] div_q;
wire       med    = (op_mode == 3'h0) && medium_speed_flag;
wire [7:0] per    = 8'h10 << medium_divider;
wire       medium_speed_flag_w = pwdata[`PMSC_CMC_MEDIUM_SPEED_FLAG_BIT];
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        stable <= 8'h00;
        gap    <= 8'h00;
        div_q  <= 2'h0;
    end else begin
        div_q  <= medium_divider;
        stable <= (!med || div_q != medium_divider) ? 8'h00 : stable + {7'h00, stable != 8'hFF};
        gap    <= cpu_clk_en ? 8'h00 : gap + {7'h00, gap != 8'hFF};
    end
end
default clocking @(posedge mclk); endclocking
default disable iff (!rst_n);
sleep_standby_a: assert property ((op_mode == 3'h0 && sleep_req && standby_select)
    |=> (op_mode == 3'h4 || op_mode == 3'h5)) else $error("active sleep not to standby");
sleep_plain_a: assert property ((op_mode == 3'h0 && sleep_req && !standby_select)
    |=> op_mode == 3'h2) else $error("active sleep not to sleep");
sub_watch_a: assert property ((op_mode == 3'h1 && sleep_req && standby_select)
    |=> op_mode == 3'h5) else $error("subactive sleep not to watch");
full_speed_a: assert property ((op_mode == 3'h0 && !medium_speed_flag)[*3]
    |-> cpu_clk_en) else $error("high-speed clock enable missing");
medium_speed_flag_write_a: assert property ((psel && penable && pready && pwrite && pstrb[0]
    && paddr == `PMSC_OFS_CMC) |=> medium_speed_flag == $past(medium_speed_flag_w))
    else $error("medium-speed flag not written");
med_pulse_a: assert property (stable > 8'h82
    |-> (cpu_clk_en == (gap == per - 8'h01)) && (gap < per)) else $error("medium pulse spacing");
cover property (op_mode == 3'h0 && sleep_req && standby_select);
cover property (op_mode == 3'h1 && sleep_req && standby_select);
cover property (stable > 8'h82 && cpu_clk_en && medium_divider == 2'h3);
endmodule // pmsc_chk
bind pmsc_top pmsc_chk u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .sleep_req(sleep_req), .cpu_clk_en(cpu_clk_en), .op_mode(op_mode),
    .standby_select(standby_select), .medium_speed_flag(medium_speed_flag),
    .medium_divider(medium_divider));

//--- tb/testbench.sv
`timescale 1ns/1ps
`include "pmsc_defines.vh"
module testbench;
reg         mclk           = 1'b0;
reg         rst_n          = 1'b0;
reg         psel           = 1'b0;
reg         penable        = 1'b0;
reg         pwrite         = 1'b0;
reg  [11:0] paddr          = 12'h000;
reg  [31:0] pwdata         = 32'h0;
reg  [3:0]  pstrb          = 4'hF;
reg         sleep_req      = 1'b0;
reg         wake_req       = 1'b0;
reg         watch_timer_on = 1'b0;
reg         sub_clk_in     = 1'b0;
reg  [2:0]  sub_cnt        = 3'h0;
reg  [31:0] rng            = 32'h0000430C;
reg  [33:0] note;
reg  [7:0]  last;
reg  [33:0] note_q[$];
wire        pready;
wire [31:0] prdata;
wire        pslverr;
wire        cpu_clk_en;
wire [2:0]  op_mode;
wire        standby_select;
wire [2:0]  standby_wait_sel;
wire        low_speed_flag;
wire        medium_speed_flag;
wire [1:0]  medium_divider;
wire [1:0]  subactive_divider;
wire        noise_sample_select;
wire        direct_transition_enable;
reg  [7:0]  got;
integer     error_cnt      = 0;
integer     checks_done    = 0;
integer     i;
always #25 mclk = ~mclk;
pmsc_top u_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .sleep_req(sleep_req), .wake_req(wake_req),
    .watch_timer_on(watch_timer_on), .sub_clk_in(sub_clk_in), .cpu_clk_en(cpu_clk_en),
    .op_mode(op_mode), .standby_select(standby_select), .standby_wait_sel(standby_wait_sel),
    .low_speed_flag(low_speed_flag), .medium_speed_flag(medium_speed_flag),
    .medium_divider(medium_divider), .subactive_divider(subactive_divider),
    .noise_sample_select(noise_sample_select),
    .direct_transition_enable(direct_transition_enable));
// ----------
// subclock source and result monitor
// ----------
always @(posedge mclk) begin
    sub_cnt    <= sub_cnt + 3'h1;
    sub_clk_in <= sub_cnt[2];
end
always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1) begin
        note = note_q.pop_front();
        checks_done = checks_done + 1;
        if (pslverr !== note[32] || (note[33] && prdata !== note[31:0])) begin
            error_cnt = error_cnt + 1;
            $display("ERROR t=%0t exp=%h got=%h", $time, note[32:0], {pslverr, prdata});
        end
        // field outputs must mirror the register word that the read expects
        if (note[33]) begin
            if (paddr == `PMSC_OFS_SSC)
                got = {standby_select, standby_wait_sel, low_speed_flag, note[2],
                       medium_divider};
            else if (paddr == `PMSC_OFS_CMC)
                got = {note[7:5], noise_sample_select, direct_transition_enable,
                       medium_speed_flag, subactive_divider};
            else
                got = {note[7:4], medium_speed_flag, op_mode};
            checks_done = checks_done + 1;
            if (got !== note[7:0]) begin
                error_cnt = error_cnt + 1;
                $display("ERROR t=%0t exp=%h got=%h", $time, note[7:0], got);
            end
        end
    end
end
function [31:0] xs(input [31:0] s);
    begin
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    end
endfunction
task tally_and_finish;
    begin
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
endtask
task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s, input [33:0] n);
    integer k;
    begin
        note_q.push_back(n);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        k = 1;
        while (pready !== 1'b1 && k < 20) begin
            @(posedge mclk);
            k = k + 1;
        end
        if (k >= 20) begin
            error_cnt = error_cnt + 1;
            tally_and_finish;
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    end
endtask
task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d, 4'hF, 34'h0);
endtask
task rd(input [11:0] a, input [7:0] e);
    apb(1'b0, a, 32'h0, 4'hF, {2'b10, 24'h0, e});
endtask
// pulse sleep (s=1) or wake, then read back the mode
task ev(input s, input [7:0] e);
    begin
        sleep_req <= s;
        wake_req  <= !s;
        @(posedge mclk);
        sleep_req <= 1'b0;
        wake_req  <= 1'b0;
        @(posedge mclk);
        rd(`PMSC_OFS_STAT, e);
    end
endtask
// count cpu clock enable pulses over n edges and compare with e
task count_en(input [15:0] n, input [15:0] e);
    integer c;
    integer m;
    begin
        c = 0;
        for (m = 0; m < n; m = m + 1) begin
            @(posedge mclk);
            if (cpu_clk_en === 1'b1)
                c = c + 1;
        end
        checks_done = checks_done + 1;
        if (c !== e) begin
            error_cnt = error_cnt + 1;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, c);
        end
    end
endtask
initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(`PMSC_OFS_SSC, 8'h07);
    rd(`PMSC_OFS_CMC, 8'hF0);
    rd(`PMSC_OFS_STAT, 8'h00);
    apb(1'b0, 12'h00C, 32'h0, 4'hF, {2'b01, 32'h0});
    apb(1'b1, 12'h010, 32'hFF, 4'hF, {2'b01, 32'h0});
    $display("test reset_map done");
    for (i = 0; i < 6; i = i + 1) begin
        rng = xs(rng);
        last = rng[7:0] | 8'hE0;
        wr(`PMSC_OFS_CMC, rng);
        rd(`PMSC_OFS_CMC, last);
        wr(`PMSC_OFS_SSC, rng >> 8);
        rd(`PMSC_OFS_SSC, rng[15:8] | 8'h04);
    end
    apb(1'b1, `PMSC_OFS_CMC, {24'h0, ~last}, 4'hE, 34'h0);
    rd(`PMSC_OFS_CMC, last);
    $display("test flag_rw done");
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(`PMSC_OFS_CMC, 8'hF0);
    rd(`PMSC_OFS_SSC, 8'h07);
    rd(`PMSC_OFS_STAT, 8'h00);
    $display("test mid_reset done");
    wr(`PMSC_OFS_CMC, 32'h04);
    for (i = 0; i < 4; i = i + 1) begin
        wr(`PMSC_OFS_SSC, i);
        repeat (400) @(posedge mclk);
        count_en(16'h0100, 16'h0010 >> i);
        rd(`PMSC_OFS_STAT, 8'h08);
    end
    wr(`PMSC_OFS_CMC, 32'h00);
    repeat (10) @(posedge mclk);
    count_en(16'h0040, 16'h0040);
    rd(`PMSC_OFS_STAT, 8'h00);
    $display("test speed done");
    wr(`PMSC_OFS_SSC, 32'h80);
    ev(1'b1, 8'h04);
    ev(1'b0, 8'h00);
    watch_timer_on <= 1'b1;
    ev(1'b1, 8'h05);
    ev(1'b0, 8'h00);
    wr(`PMSC_OFS_SSC, 32'h00);
    ev(1'b1, 8'h02);
    count_en(16'h0040, 16'h0000);
    ev(1'b1, 8'h02);
    ev(1'b0, 8'h00);
    wr(`PMSC_OFS_SSC, 32'h88);
    rd(`PMSC_OFS_SSC, 8'h8C);
    ev(1'b1, 8'h05);
    count_en(16'h0040, 16'h0000);
    ev(1'b0, 8'h01);
    count_en(16'h0040, 16'h0008);
    ev(1'b1, 8'h05);
    ev(1'b0, 8'h01);
    wr(`PMSC_OFS_SSC, 32'h08);
    ev(1'b1, 8'h03);
    ev(1'b0, 8'h01);
    $display("test modes done");
    tally_and_finish;
end
endmodule // testbench
